// ===== apc_ahb_slave.sv
// AHB-Lite slave front end: write strobes in the data phase, reads with one wait state
`timescale 1ns/1ps
module apc_ahb_slave (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Register side
	output logic             wr_en,
	output logic             rd_req,
	output logic      [7:0]  reg_addr,
	output logic      [3:0]  byte_en,
	input  wire logic [31:0] rd_data
);
	import apc_pkg::*;

	apc_phase_t phase;
	logic       take;

	assign take = hsel && htrans[1] && hready;

	////////////////////////////////////////////////////////////////////////////
	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase    <= APC_PH_IDLE;
			reg_addr <= 8'h00;
			byte_en  <= 4'h0;
		end
		else if (take)
		begin
			phase    <= hwrite ? APC_PH_WR : APC_PH_RD;
			reg_addr <= {haddr[7:2], 2'b00};
			byte_en  <= apc_byte_lanes(hsize, haddr[1:0]);
		end
		else
		begin
			phase <= APC_PH_IDLE;
		end
	end

	// Read data registered in the wait cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
		end
		else if (rd_req)
		begin
			hrdata <= rd_data;
		end
	end

	always_comb
	begin
		case (phase)
			APC_PH_WR:
			begin
				wr_en  = 1'b1;
				rd_req = 1'b0;
			end
			APC_PH_RD:
			begin
				wr_en  = 1'b0;
				rd_req = 1'b1;
			end
			default:
			begin
				wr_en  = 1'b0;
				rd_req = 1'b0;
			end
		endcase
	end

	assign hreadyout = !rd_req;
	assign hresp     = 1'b0;

endmodule : apc_ahb_slave

// ===== apc_atomic_reg.sv
// Staged divider register that applies its value when the committing byte is written
`timescale 1ns/1ps
module apc_atomic_reg #(
	parameter int               WIDTH       = 27,
	parameter int               COMMIT_LANE = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [3:0]       byte_en,
	input  wire logic [31:0]      wdata,
	// Values
	output logic      [WIDTH-1:0] staged,
	output logic      [WIDTH-1:0] applied
);

	logic [WIDTH-1:0] next_staged;

	////////////////////////////////////////////////////////////////////////////
	// Merge written bytes into staging
	always_comb
	begin
		next_staged = staged;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (wr_en && byte_en[i/8])
			begin
				next_staged[i] = wdata[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			staged <= RESET_VALUE;
		end
		else
		begin
			staged <= next_staged;
		end
	end

	// Commit on the most significant byte
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			applied <= RESET_VALUE;
		end
		else if (wr_en && byte_en[COMMIT_LANE])
		begin
			applied <= next_staged;
		end
	end

endmodule : apc_atomic_reg

// ===== apc_config_bank.sv
// Analog PLL configuration register bank behind an AHB-Lite slave
`timescale 1ns/1ps
module apc_config_bank (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Analog PLL settings
	output apc_pkg::apc_pll_ctrl_t     pll_ctrl
);
	import apc_pkg::*;

	logic                  wr_en;
	logic                  rd_req;
	logic [7:0]            reg_addr;
	logic [3:0]            byte_en;
	logic [31:0]           rd_data;
	logic                  wr_frac;
	logic                  wr_int;
	logic                  wr_low;
	logic [APC_FRAC_W-1:0] frac_staged;
	logic [APC_FRAC_W-1:0] frac_numerator;
	logic [APC_INT_W-1:0]  int_staged;
	logic [APC_INT_W-1:0]  integer_divider;
	logic [7:0]            sdm_cfg;
	logic [7:0]            src_cfg;
	logic [7:0]            lpf_cfg;

	////////////////////////////////////////////////////////////////////////////
	// Bus front end
	apc_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_en     (wr_en),
		.rd_req    (rd_req),
		.reg_addr  (reg_addr),
		.byte_en   (byte_en),
		.rd_data   (rd_data)
	);

	assign wr_frac = wr_en && (reg_addr == APC_OFS_FRAC);
	assign wr_int  = wr_en && (reg_addr == APC_OFS_INT);
	assign wr_low  = wr_en && byte_en[0];

	////////////////////////////////////////////////////////////////////////////
	// Atomic divider registers
	apc_atomic_reg #(
		.WIDTH       (APC_FRAC_W),
		.COMMIT_LANE (APC_FRAC_LANE),
		.RESET_VALUE (APC_FRAC_RST)
	) u_frac (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_en   (wr_frac),
		.byte_en (byte_en),
		.wdata   (hwdata),
		.staged  (frac_staged),
		.applied (frac_numerator)
	);

	apc_atomic_reg #(
		.WIDTH       (APC_INT_W),
		.COMMIT_LANE (APC_INT_LANE),
		.RESET_VALUE (APC_INT_RST)
	) u_int (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_en   (wr_int),
		.byte_en (byte_en),
		.wdata   (hwdata),
		.staged  (int_staged),
		.applied (integer_divider)
	);

	////////////////////////////////////////////////////////////////////////////
	// Modulator configuration
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sdm_cfg <= APC_SDM_RST;
		end
		else if (wr_low && (reg_addr == APC_OFS_SDM))
		begin
			sdm_cfg <= hwdata[7:0] & APC_SDM_MASK;
		end
	end

	// Reference source and doubler
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			src_cfg <= APC_CFG_RST;
		end
		else if (wr_low && (reg_addr == APC_OFS_CFG))
		begin
			src_cfg <= hwdata[7:0] & APC_CFG_MASK;
		end
	end

	// Loop filter codes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lpf_cfg <= APC_LPF_RST;
		end
		else if (wr_low && (reg_addr == APC_OFS_LPF))
		begin
			lpf_cfg <= hwdata[7:0] & APC_LPF_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer
	always_comb
	begin
		case (reg_addr)
			APC_OFS_FRAC:
			begin
				rd_data = {5'h00, frac_staged};
			end
			APC_OFS_INT:
			begin
				rd_data = {22'h000000, int_staged};
			end
			APC_OFS_SDM:
			begin
				rd_data = {24'h000000, sdm_cfg};
			end
			APC_OFS_CFG:
			begin
				rd_data = {24'h000000, src_cfg};
			end
			APC_OFS_LPF:
			begin
				rd_data = {24'h000000, lpf_cfg};
			end
			default:
			begin
				rd_data = 32'h00000000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Drive the analog settings
	always_comb
	begin
		pll_ctrl.frac_numerator       = frac_numerator;
		pll_ctrl.integer_divider      = integer_divider;
		pll_ctrl.modulator_order      = sdm_cfg[APC_SDM_ORDER_LSB +: 2];
		pll_ctrl.dither_enable        = sdm_cfg[APC_SDM_DITHER_BIT];
		pll_ctrl.dither_shaping       = sdm_cfg[APC_SDM_SHAPE_BIT];
		pll_ctrl.dither_gain          = sdm_cfg[APC_SDM_GAIN_LSB +: 2];
		pll_ctrl.ref_select           = src_cfg[APC_CFG_REF_BIT];
		pll_ctrl.doubler_enable       = src_cfg[APC_CFG_DBL_BIT];
		pll_ctrl.vco_filter_bypass    = lpf_cfg[APC_LPF_BYP_BIT];
		pll_ctrl.pole_capacitor_code  = lpf_cfg[APC_LPF_CAP_LSB +: 3];
		pll_ctrl.filter_resistor_code = lpf_cfg[APC_LPF_RES_LSB +: 4];
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_frac_commit_full: assert property (
		wr_frac && (byte_en == 4'hf) |=> (frac_numerator == $past(hwdata[26:0])))
		else $error("fraction not applied on full word write");

	a_frac_hold_low: assert property (
		wr_frac && !byte_en[3] |=> $stable(frac_numerator))
		else $error("fraction applied without top byte");

	a_int_commit_full: assert property (
		wr_int && (byte_en == 4'hf) |=> (integer_divider == $past(hwdata[9:0])))
		else $error("integer divider not applied on full word write");

	a_int_hold_low: assert property (
		wr_int && !byte_en[1] |=> $stable(integer_divider))
		else $error("integer divider applied without upper byte");

	a_frac_resv_zero: assert property (
		rd_req && (reg_addr == APC_OFS_FRAC) |=> (hrdata[31:27] == 5'h00) && hreadyout)
		else $error("fraction reserved bits not zero");

	a_int_resv_zero: assert property (
		rd_req && (reg_addr == APC_OFS_INT) |=> (hrdata[31:10] == 22'h000000))
		else $error("integer reserved bits not zero");

	a_sdm_read_map: assert property (
		rd_req && (reg_addr == APC_OFS_SDM) |=>
		(hrdata[7:0] == {2'b00, pll_ctrl.dither_enable, pll_ctrl.dither_shaping,
		pll_ctrl.dither_gain, pll_ctrl.modulator_order}))
		else $error("modulator readback differs from applied settings");

	a_src_read_map: assert property (
		rd_req && (reg_addr == APC_OFS_CFG) |=>
		(hrdata[7:0] == {6'h00, pll_ctrl.ref_select, pll_ctrl.doubler_enable}))
		else $error("source readback differs from applied settings");

	a_lpf_read_map: assert property (
		rd_req && (reg_addr == APC_OFS_LPF) |=>
		(hrdata[7:0] == {pll_ctrl.vco_filter_bypass, pll_ctrl.pole_capacitor_code,
		pll_ctrl.filter_resistor_code}))
		else $error("loop filter readback differs from applied settings");

	a_read_one_wait: assert property (
		rd_req |-> !hreadyout ##1 (hreadyout && !rd_req))
		else $error("read wait state not exactly one cycle");

	// Register state checks
	a_frac_commit_top: assert property (
		wr_frac && byte_en[3] |=> (frac_numerator == frac_staged))
		else $error("fraction applied value differs from staged value");

	a_frac_commit_lane: assert property (
		wr_frac && byte_en[3] |=> (frac_numerator[26:24] == $past(hwdata[26:24])))
		else $error("fraction top bits not taken from committing byte");

	a_frac_idle_hold: assert property (
		!wr_frac |=> $stable(frac_numerator))
		else $error("fraction changed without a write");

	a_frac_staged_lane: assert property (
		wr_frac && byte_en[0] |=> (frac_staged[7:0] == $past(hwdata[7:0])))
		else $error("fraction low byte not staged");

	a_frac_rd_staged: assert property (
		rd_req && (reg_addr == APC_OFS_FRAC) |=> (hrdata[26:0] == frac_staged))
		else $error("fraction readback differs from staged value");

	a_int_commit_top: assert property (
		wr_int && byte_en[1] |=> (integer_divider == int_staged))
		else $error("integer applied value differs from staged value");

	a_int_commit_lane: assert property (
		wr_int && byte_en[1] |=> (integer_divider[9:8] == $past(hwdata[9:8])))
		else $error("integer top bits not taken from committing byte");

	a_int_idle_hold: assert property (
		!wr_int |=> $stable(integer_divider))
		else $error("integer divider changed without a write");

	a_int_staged_lane: assert property (
		wr_int && byte_en[0] |=> (int_staged[7:0] == $past(hwdata[7:0])))
		else $error("integer low byte not staged");

	a_int_rd_staged: assert property (
		rd_req && (reg_addr == APC_OFS_INT) |=> (hrdata[9:0] == int_staged))
		else $error("integer readback differs from staged value");

	a_sdm_write_mask: assert property (
		wr_low && (reg_addr == APC_OFS_SDM) |=> (sdm_cfg == {2'b00, $past(hwdata[5:0])}))
		else $error("modulator write not masked");

	a_sdm_lane_hold: assert property (
		wr_en && (reg_addr == APC_OFS_SDM) && !byte_en[0] |=> $stable(sdm_cfg))
		else $error("modulator written without its byte lane");

	a_sdm_idle_hold: assert property (
		!(wr_low && (reg_addr == APC_OFS_SDM)) |=> $stable(sdm_cfg))
		else $error("modulator settings changed without a write");

	a_sdm_resv_zero: assert property (
		sdm_cfg[7:6] == 2'b00)
		else $error("modulator reserved bits set");

	a_cfg_write_mask: assert property (
		wr_low && (reg_addr == APC_OFS_CFG) |=> (src_cfg == {6'h00, $past(hwdata[1:0])}))
		else $error("source write not masked");

	a_cfg_idle_hold: assert property (
		!(wr_low && (reg_addr == APC_OFS_CFG)) |=> $stable(src_cfg))
		else $error("source settings changed without a write");

	a_cfg_resv_zero: assert property (
		src_cfg[7:2] == 6'h00)
		else $error("source reserved bits set");

	a_lpf_write_all: assert property (
		wr_low && (reg_addr == APC_OFS_LPF) |=> (lpf_cfg == $past(hwdata[7:0])))
		else $error("loop filter write not taken");

	a_lpf_idle_hold: assert property (
		!(wr_low && (reg_addr == APC_OFS_LPF)) |=> $stable(lpf_cfg))
		else $error("loop filter settings changed without a write");

	a_unmapped_rd_zero: assert property (
		rd_req && (reg_addr > APC_OFS_LPF) |=> (hrdata == 32'h00000000))
		else $error("unmapped read not zero");

	a_reset_dividers: assert property (
		$rose(hresetn) |-> (frac_numerator == APC_FRAC_RST) && (integer_divider == APC_INT_RST))
		else $error("divider reset values wrong");

	a_reset_modulator: assert property (
		$rose(hresetn) |-> (pll_ctrl.modulator_order == 2'h3) && !pll_ctrl.dither_enable &&
		!pll_ctrl.dither_shaping && (pll_ctrl.dither_gain == 2'h0))
		else $error("modulator reset values wrong");

	a_reset_source: assert property (
		$rose(hresetn) |-> pll_ctrl.doubler_enable && !pll_ctrl.ref_select)
		else $error("source reset values wrong");

	a_reset_filter: assert property (
		$rose(hresetn) |-> !pll_ctrl.vco_filter_bypass && (pll_ctrl.pole_capacitor_code == 3'h7) &&
		(pll_ctrl.filter_resistor_code == 4'h6))
		else $error("loop filter reset values wrong");

endmodule : apc_config_bank

// ===== apc_pkg.sv
// Package: register map, field layout, reset values and bus types of the PLL configuration bank
package apc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] APC_OFS_FRAC = 8'h00;
	localparam logic [7:0] APC_OFS_INT  = 8'h04;
	localparam logic [7:0] APC_OFS_SDM  = 8'h08;
	localparam logic [7:0] APC_OFS_CFG  = 8'h0c;
	localparam logic [7:0] APC_OFS_LPF  = 8'h10;

	////////////////////////////////////////////////////////////////////////////
	// Field widths and commit byte lanes
	localparam int APC_FRAC_W     = 27;
	localparam int APC_INT_W      = 10;
	localparam int APC_FRAC_LANE  = 3;
	localparam int APC_INT_LANE   = 1;
	localparam int APC_DEN_LOG2   = 27;

	////////////////////////////////////////////////////////////////////////////
	// Field positions in the byte-wide registers
	localparam int APC_SDM_ORDER_LSB  = 0;
	localparam int APC_SDM_GAIN_LSB   = 2;
	localparam int APC_SDM_SHAPE_BIT  = 4;
	localparam int APC_SDM_DITHER_BIT = 5;
	localparam int APC_CFG_DBL_BIT    = 0;
	localparam int APC_CFG_REF_BIT    = 1;
	localparam int APC_LPF_RES_LSB    = 0;
	localparam int APC_LPF_CAP_LSB    = 4;
	localparam int APC_LPF_BYP_BIT    = 7;

	////////////////////////////////////////////////////////////////////////////
	// Writable masks and reset values
	localparam logic [7:0] APC_SDM_MASK = 8'h3f;
	localparam logic [7:0] APC_CFG_MASK = 8'h03;
	localparam logic [7:0] APC_LPF_MASK = 8'hff;
	localparam logic [APC_FRAC_W-1:0] APC_FRAC_RST = 27'h0000000;
	localparam logic [APC_INT_W-1:0]  APC_INT_RST  = 10'h06c;
	localparam logic [7:0] APC_SDM_RST = 8'h03;
	localparam logic [7:0] APC_CFG_RST = 8'h01;
	localparam logic [7:0] APC_LPF_RST = 8'h76;

	////////////////////////////////////////////////////////////////////////////
	// Bus phase encoding
	typedef enum logic [1:0]
	{
		APC_PH_IDLE = 2'b00,
		APC_PH_WR   = 2'b01,
		APC_PH_RD   = 2'b10
	} apc_phase_t;

	// Settings driven into the analog PLL
	typedef struct packed
	{
		logic [APC_FRAC_W-1:0] frac_numerator;
		logic [APC_INT_W-1:0]  integer_divider;
		logic [1:0]            modulator_order;
		logic                  dither_enable;
		logic                  dither_shaping;
		logic [1:0]            dither_gain;
		logic                  ref_select;
		logic                  doubler_enable;
		logic                  vco_filter_bypass;
		logic [2:0]            pole_capacitor_code;
		logic [3:0]            filter_resistor_code;
	} apc_pll_ctrl_t;

	// Byte lanes touched by one AHB transfer
	function automatic logic [3:0] apc_byte_lanes(input logic [2:0] size, input logic [1:0] addr);
		logic [3:0] lanes;
		case (size)
			3'h0:
			begin
				lanes = 4'h1 << addr;
			end
			3'h1:
			begin
				lanes = addr[1] ? 4'hc : 4'h3;
			end
			default:
			begin
				lanes = 4'hf;
			end
		endcase
		return lanes;
	endfunction : apc_byte_lanes

endpackage : apc_pkg

// ===== tb.sv
// Self-checking testbench for the PLL configuration register bank
`timescale 1ns/1ps
module tb;
	import apc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Signals
	logic          hclk = 1'b0;
	logic          hresetn;
	logic          hsel;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [2:0]    hsize;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic          hreadyout;
	logic          hresp;
	apc_pll_ctrl_t pll_ctrl;
	apc_pll_ctrl_t exp_ctrl;
	int            fail_count;
	int            samples_checked;

	apc_config_bank u_apc_config_bank (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.pll_ctrl  (pll_ctrl)
	);

	always #10 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////
	// Compare and bus tasks
	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_word

	task automatic chk_ctrl(input string name);
		samples_checked++;
		if (pll_ctrl !== exp_ctrl)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp_ctrl, pll_ctrl);
		end
	endtask : chk_ctrl

	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1)
		begin
			fail_count++;
			$display("BAD hreadyout expected 1 seen %b", hreadyout);
		end
	endtask : wait_rdy

	task automatic bus_wr(input logic [7:0] a, input logic [2:0] s, input logic [31:0] d);
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= 1'b1;
		hsize  <= s;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
	endtask : bus_wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= 1'b0;
		hsize  <= 3'h2;
		wait_rdy();
		htrans <= 2'b00;
		wait_rdy();
		chk_word(name, exp, hrdata);
		chk_word("hresp", 32'h00000000, {31'h0, hresp});
	endtask : rd_chk

	// Word write, then pll settings and readback
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] rd, input string name);
		bus_wr(a, 3'h2, d);
		@(posedge hclk);
		chk_ctrl(name);
		rd_chk(a, rd, name);
	endtask : wr_chk

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset_vals;
		exp_ctrl = '0;
		exp_ctrl.integer_divider      = 10'h06c;
		exp_ctrl.modulator_order      = 2'h3;
		exp_ctrl.doubler_enable       = 1'b1;
		exp_ctrl.pole_capacitor_code  = 3'h7;
		exp_ctrl.filter_resistor_code = 4'h6;
		chk_ctrl("ctrl_reset");
		rd_chk(APC_OFS_FRAC, 32'h00000000, "frac_reset");
		rd_chk(APC_OFS_INT, 32'h0000006c, "int_reset");
		rd_chk(APC_OFS_SDM, 32'h00000003, "sdm_reset");
		rd_chk(APC_OFS_CFG, 32'h00000001, "cfg_reset");
		rd_chk(APC_OFS_LPF, 32'h00000076, "lpf_reset");
	endtask : t_reset_vals

	task automatic t_frac;
		bus_wr(8'h00, 3'h0, 32'h00000012);
		bus_wr(8'h01, 3'h0, 32'h00003400);
		bus_wr(8'h02, 3'h0, 32'h00560000);
		@(posedge hclk);
		chk_ctrl("frac_staged");
		rd_chk(APC_OFS_FRAC, 32'h00563412, "frac_stage_rd");
		bus_wr(8'h03, 3'h0, 32'hff000000);
		exp_ctrl.frac_numerator = 27'h7563412;
		@(posedge hclk);
		chk_ctrl("frac_commit");
		rd_chk(APC_OFS_FRAC, 32'h07563412, "frac_rd");
		bus_wr(8'h00, 3'h1, 32'h0000abcd);
		bus_wr(8'h02, 3'h1, 32'h00010000);
		exp_ctrl.frac_numerator = 27'h001abcd;
		@(posedge hclk);
		chk_ctrl("frac_half");
		exp_ctrl.frac_numerator = 27'h6dcba98;
		wr_chk(APC_OFS_FRAC, 32'hfedcba98, 32'h06dcba98, "frac_word");
	endtask : t_frac

	task automatic t_int;
		bus_wr(8'h04, 3'h0, 32'h000000a5);
		@(posedge hclk);
		chk_ctrl("int_staged");
		rd_chk(APC_OFS_INT, 32'h000000a5, "int_stage_rd");
		bus_wr(8'h05, 3'h0, 32'h0000ff00);
		exp_ctrl.integer_divider = 10'h3a5;
		@(posedge hclk);
		chk_ctrl("int_commit");
		rd_chk(APC_OFS_INT, 32'h000003a5, "int_rd");
		exp_ctrl.integer_divider = 10'h123;
		wr_chk(APC_OFS_INT, 32'hffff0123, 32'h00000123, "int_word");
	endtask : t_int

	task automatic t_sdm;
		logic [7:0] tbl [4];
		tbl = '{8'hc0, 8'hd5, 8'hea, 8'hff};
		foreach (tbl[i])
		begin
			exp_ctrl.modulator_order = tbl[i][1:0];
			exp_ctrl.dither_gain     = tbl[i][3:2];
			exp_ctrl.dither_shaping  = tbl[i][4];
			exp_ctrl.dither_enable   = tbl[i][5];
			wr_chk(APC_OFS_SDM, {24'hffffff, tbl[i]}, {26'h0, tbl[i][5:0]}, "sdm");
		end
	endtask : t_sdm

	task automatic t_cfg;
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
		begin
			v = 8'hfc | 8'(i);
			exp_ctrl.ref_select     = v[1];
			exp_ctrl.doubler_enable = v[0];
			wr_chk(APC_OFS_CFG, {24'hffffff, v}, {30'h0, v[1:0]}, "cfg");
		end
	endtask : t_cfg

	task automatic t_lpf;
		logic [7:0] v;
		for (int i = 0; i < 16; i++)
		begin
			v = 8'(i * 17);
			exp_ctrl.vco_filter_bypass    = v[7];
			exp_ctrl.pole_capacitor_code  = v[6:4];
			exp_ctrl.filter_resistor_code = v[3:0];
			wr_chk(APC_OFS_LPF, {24'h000000, v}, {24'h0, v}, "lpf");
		end
	endtask : t_lpf

	task automatic t_unmapped;
		bus_wr(8'h14, 3'h2, 32'hffffffff);
		bus_wr(8'h09, 3'h0, 32'h00000000);
		@(posedge hclk);
		chk_ctrl("unmapped_wr");
		rd_chk(8'h14, 32'h00000000, "unmapped_rd");
		rd_chk(APC_OFS_SDM, 32'h0000003f, "sdm_lane");
		hsel <= 1'b0;
		bus_wr(APC_OFS_LPF, 3'h2, 32'h00000000);
		hsel <= 1'b1;
		@(posedge hclk);
		chk_ctrl("deselected_wr");
		rd_chk(APC_OFS_LPF, 32'h000000ff, "deselected_rd");
	endtask : t_unmapped

	////////////////////////////////////////////////////////////////////////////
	// Verdict and run control
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		end_of_test();
	end

	initial
	begin
		hresetn         = 1'b0;
		hsel            = 1'b1;
		haddr           = 32'h00000000;
		htrans          = 2'b00;
		hwrite          = 1'b0;
		hsize           = 3'h2;
		hwdata          = 32'h00000000;
		fail_count      = 0;
		samples_checked = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset_vals();
		t_frac();
		t_int();
		t_sdm();
		t_cfg();
		t_lpf();
		t_unmapped();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset_vals();
		end_of_test();
	end

endmodule : tb
